// ### logic/monitor_config_status_regs.v
/*
  Configuration and status bytes of the temperature and voltage monitor,
  with alert and over-temperature outputs and the conversion sequencer.
  Assumes the serial front end turns each command into a one-cycle
  read or write strobe with its command code, and that trip, fault and
  over-limit inputs come from comparator logic on mclk.
  Diode faults are live levels and never raise the alert output.
*/
`timescale 1ns/1ps
`default_nettype none
`include "monitor_regs_map.vh"

module monitor_config_status_regs #(
  parameter CONV_COUNT = `CONVERSION_CYCLES,
  parameter IDLE_COUNT = `IDLE_GAP_CYCLES
) (
  input  wire       mclk,
  input  wire       reset,
  input  wire [7:0] reg_addr,
  input  wire       reg_write,
  input  wire       reg_read,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       internal_high_trip,
  input  wire       internal_low_trip,
  input  wire       remote_one_high_trip,
  input  wire       remote_one_low_trip,
  input  wire       remote_two_high_trip,
  input  wire       remote_two_low_trip,
  input  wire       remote_one_diode_fault,
  input  wire       remote_two_diode_fault,
  input  wire       internal_over_limit,
  input  wire       remote_one_over_limit,
  input  wire       remote_two_over_limit,
  input  wire       input_three_window_trip,
  input  wire       input_two_window_trip,
  input  wire       input_one_window_trip,
  input  wire       supply_window_trip,
  output reg        alert_n,
  output reg        overtemp_output_n,
  output wire       standby,
  output wire       busy,
  output wire [2:0] conv_channel,
  output wire       conv_start
);

  // ----------------------------------------------------------------------
  // configuration bytes
  // ----------------------------------------------------------------------
  reg [7:0] alert_mask_and_standby_config;
  reg [7:0] measurement_disable_config;
  wire      write_config_one;
  wire      write_config_two;
  wire [7:0] next_config_two;

  // writes to read-only or unknown codes fall through both decodes
  assign write_config_one = reg_write && (reg_addr == `CMD_WRITE_CONFIG_ONE);
  assign write_config_two = reg_write && (reg_addr == `CMD_WRITE_CONFIG_TWO);

  // reserved bit is held at zero whatever the host writes
  assign next_config_two = {reg_wdata[7:1], 1'b0};

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      alert_mask_and_standby_config <= `CONFIG_ONE_RESET;
    end else if (write_config_one) begin
      alert_mask_and_standby_config <= reg_wdata;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      measurement_disable_config <= `CONFIG_TWO_RESET;
    end else if (write_config_two) begin
      measurement_disable_config <= next_config_two;
    end
  end

  wire       mask_all;
  wire       mask_r1;
  wire       mask_r2;
  wire [3:0] mask_volt;

  assign mask_all  = alert_mask_and_standby_config[`CFG1_MASK_ALL];
  assign mask_r1   = alert_mask_and_standby_config[`CFG1_MASK_REMOTE_ONE];
  assign mask_r2   = alert_mask_and_standby_config[`CFG1_MASK_REMOTE_TWO];
  // same order as volt_flags: in3, in2, in1, supply
  assign mask_volt = {alert_mask_and_standby_config[`CFG1_MASK_INPUT_THREE],
                      alert_mask_and_standby_config[`CFG1_MASK_INPUT_TWO],
                      alert_mask_and_standby_config[`CFG1_MASK_INPUT_ONE],
                      alert_mask_and_standby_config[`CFG1_MASK_SUPPLY]};

  assign standby = alert_mask_and_standby_config[`CFG1_STANDBY];

  // ----------------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------------
  wire [6:0] skip;
  wire       skip_internal;
  wire       skip_remote_one;
  wire       skip_remote_two;
  wire       skip_supply;
  wire       skip_input_one;
  wire       skip_input_two;
  wire       skip_input_three;

  assign skip_internal    = measurement_disable_config[`CFG2_SKIP_INTERNAL];
  assign skip_remote_one  = measurement_disable_config[`CFG2_SKIP_REMOTE_ONE];
  assign skip_remote_two  = measurement_disable_config[`CFG2_SKIP_REMOTE_TWO];
  assign skip_supply      = measurement_disable_config[`CFG2_SKIP_SUPPLY];
  assign skip_input_one   = measurement_disable_config[`CFG2_SKIP_INPUT_ONE];
  assign skip_input_two   = measurement_disable_config[`CFG2_SKIP_INPUT_TWO];
  assign skip_input_three = measurement_disable_config[`CFG2_SKIP_INPUT_THREE];

  // a skip change lands at the next channel step, not mid-conversion;
  // the sequencer only paces, the readings come from outside
  // channel order: internal, remote one, remote two, supply, in1, in2, in3
  assign skip = {skip_input_three, skip_input_two, skip_input_one, skip_supply,
                 skip_remote_two, skip_remote_one, skip_internal};

  conversion_sequencer #(
    .CHANNELS   (7),
    .CONV_COUNT (CONV_COUNT),
    .IDLE_COUNT (IDLE_COUNT)
  ) sequencer (
    .mclk          (mclk),
    .reset         (reset),
    .run           (~standby),
    .skip          (skip),
    .busy          (busy),
    .channel       (conv_channel),
    .channel_start (conv_start)
  );

  // ----------------------------------------------------------------------
  // latched trip flags
  // ----------------------------------------------------------------------
  wire read_status_one = reg_read && (reg_addr == `CMD_READ_STATUS_ONE);
  wire read_status_two = reg_read && (reg_addr == `CMD_READ_STATUS_TWO);
  wire [5:0] temp_flags;
  wire [3:0] volt_flags;
  wire [5:0] temp_trips;
  wire [3:0] volt_trips;

  // ----------------------------------------------------------------------
  // trip inputs
  // ----------------------------------------------------------------------
  // masks never stop latching, so a read shows trips hidden from alert
  assign temp_trips = {internal_high_trip, internal_low_trip,
                       remote_one_high_trip, remote_one_low_trip,
                       remote_two_high_trip, remote_two_low_trip};
  assign volt_trips = {input_three_window_trip, input_two_window_trip,
                       input_one_window_trip, supply_window_trip};

  // temp_flags order: int high, int low, high, low, high, low
  sticky_flags #(
    .WIDTH (6)
  ) temp_latch (
    .mclk  (mclk),
    .reset (reset),
    .set   (temp_trips),
    .clear (read_status_one),
    .flags (temp_flags)
  );

  // volt_flags order: in3, in2, in1, supply
  sticky_flags #(
    .WIDTH (4)
  ) volt_latch (
    .mclk  (mclk),
    .reset (reset),
    .set   (volt_trips),
    .clear (read_status_two),
    .flags (volt_flags)
  );

  // ----------------------------------------------------------------------
  // status byte images
  // ----------------------------------------------------------------------
  wire [7:0] temperature_alert_status;
  wire [7:0] overtemp_voltage_alert_status;

  assign temperature_alert_status[`ST1_BUSY] = busy;
  assign temperature_alert_status[`ST1_INTERNAL_HIGH] = temp_flags[5];
  assign temperature_alert_status[`ST1_INTERNAL_LOW] = temp_flags[4];
  assign temperature_alert_status[`ST1_REMOTE_ONE_HIGH] = temp_flags[3];
  assign temperature_alert_status[`ST1_REMOTE_ONE_LOW] = temp_flags[2];
  assign temperature_alert_status[`ST1_REMOTE_ONE_DIODE] = remote_one_diode_fault;
  assign temperature_alert_status[`ST1_REMOTE_TWO_HIGH] = temp_flags[1];
  assign temperature_alert_status[`ST1_REMOTE_TWO_LOW] = temp_flags[0];

  // ----------------------------------------------------------------------
  // status byte two: upper half live, lower half latched
  // ----------------------------------------------------------------------
  assign overtemp_voltage_alert_status[`ST2_INTERNAL_OVER] = internal_over_limit;
  assign overtemp_voltage_alert_status[`ST2_REMOTE_ONE_OVER] = remote_one_over_limit;
  assign overtemp_voltage_alert_status[`ST2_REMOTE_TWO_OVER] = remote_two_over_limit;
  assign overtemp_voltage_alert_status[`ST2_REMOTE_TWO_DIODE] = remote_two_diode_fault;
  assign overtemp_voltage_alert_status[`ST2_INPUT_THREE] = volt_flags[3];
  assign overtemp_voltage_alert_status[`ST2_INPUT_TWO] = volt_flags[2];
  assign overtemp_voltage_alert_status[`ST2_INPUT_ONE] = volt_flags[1];
  assign overtemp_voltage_alert_status[`ST2_SUPPLY] = volt_flags[0];

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  reg [7:0] read_value;

  // unknown codes read back as zero rather than the last byte
  always @* begin
    case (reg_addr)
      `CMD_READ_STATUS_ONE: read_value = temperature_alert_status;
      `CMD_READ_CONFIG_ONE: read_value = alert_mask_and_standby_config;
      `CMD_READ_STATUS_TWO: read_value = overtemp_voltage_alert_status;
      `CMD_READ_CONFIG_TWO: read_value = measurement_disable_config;
      default:              read_value = `UNMAPPED_READ_VALUE;
    endcase
  end

  // ----------------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------------
  // the byte is captured on the same edge that clears its latches
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= `UNMAPPED_READ_VALUE;
    end else if (reg_read) begin
      reg_rdata <= read_value;
    end
  end

  // ----------------------------------------------------------------------
  // alert and over-temperature outputs
  // ----------------------------------------------------------------------
  reg        next_alert;
  reg        next_overtemp;
  wire       internal_alert;
  wire       remote_one_alert;
  wire       remote_two_alert;
  wire [3:0] voltage_alert;
  wire       internal_overtemp_cause;
  wire       remote_one_overtemp_cause;
  wire       remote_two_overtemp_cause;

  // internal temperature trips have no mask of their own
  assign internal_alert   = temp_flags[5] | temp_flags[4];
  assign remote_one_alert = (temp_flags[3] | temp_flags[2]) & ~mask_r1;
  assign remote_two_alert = (temp_flags[1] | temp_flags[0]) & ~mask_r2;
  // voltage masks block only alert, never overtemp
  assign voltage_alert    = volt_flags & ~mask_volt;

  // internal overtemp cannot be masked: it is the last line of defence
  assign internal_overtemp_cause   = internal_over_limit;
  assign remote_one_overtemp_cause = remote_one_over_limit & ~mask_r1;
  assign remote_two_overtemp_cause = remote_two_over_limit & ~mask_r2;

  always @* begin
    next_alert = internal_alert | remote_one_alert | remote_two_alert | (|voltage_alert);
    next_alert = next_alert & ~mask_all;
    next_overtemp = internal_overtemp_cause
                  | remote_one_overtemp_cause
                  | remote_two_overtemp_cause;
  end

  // registered so the pins never glitch while masks are rewritten
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= ~next_alert;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      overtemp_output_n <= 1'b1;
    end else begin
      overtemp_output_n <= ~next_overtemp;
    end
  end

endmodule

`default_nettype wire

// ### pkg/monitor_regs_map.vh
/*
  Command codes, bit positions, reset values and timing counts of the
  monitor's configuration and status bytes.
  Assumes it is included by bare name from the design files.
*/
`ifndef MONITOR_REGS_MAP_VH
`define MONITOR_REGS_MAP_VH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define CMD_READ_STATUS_ONE     8'h02
`define CMD_READ_CONFIG_ONE     8'h03
`define CMD_WRITE_CONFIG_ONE    8'h09
`define CMD_READ_STATUS_TWO     8'h32
`define CMD_READ_CONFIG_TWO     8'h33
`define CMD_WRITE_CONFIG_TWO    8'h34

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CONFIG_ONE_RESET        8'h00
`define CONFIG_TWO_RESET        8'h00
`define UNMAPPED_READ_VALUE     8'h00

// ----------------------------------------------------------------------
// configuration byte one fields
// ----------------------------------------------------------------------
`define CFG1_MASK_ALL           7
`define CFG1_STANDBY            6
`define CFG1_MASK_REMOTE_ONE    5
`define CFG1_MASK_REMOTE_TWO    4
`define CFG1_MASK_INPUT_THREE   3
`define CFG1_MASK_INPUT_TWO     2
`define CFG1_MASK_INPUT_ONE     1
`define CFG1_MASK_SUPPLY        0

// ----------------------------------------------------------------------
// configuration byte two fields
// ----------------------------------------------------------------------
`define CFG2_SKIP_REMOTE_ONE    7
`define CFG2_SKIP_REMOTE_TWO    6
`define CFG2_SKIP_INTERNAL      5
`define CFG2_SKIP_INPUT_THREE   4
`define CFG2_SKIP_INPUT_TWO     3
`define CFG2_SKIP_INPUT_ONE     2
`define CFG2_SKIP_SUPPLY        1
`define CFG2_RESERVED           0

// ----------------------------------------------------------------------
// status byte one fields
// ----------------------------------------------------------------------
`define ST1_BUSY                7
`define ST1_INTERNAL_HIGH       6
`define ST1_INTERNAL_LOW        5
`define ST1_REMOTE_ONE_HIGH     4
`define ST1_REMOTE_ONE_LOW      3
`define ST1_REMOTE_ONE_DIODE    2
`define ST1_REMOTE_TWO_HIGH     1
`define ST1_REMOTE_TWO_LOW      0

// ----------------------------------------------------------------------
// status byte two fields
// ----------------------------------------------------------------------
`define ST2_INTERNAL_OVER       7
`define ST2_REMOTE_ONE_OVER     6
`define ST2_REMOTE_TWO_OVER     5
`define ST2_REMOTE_TWO_DIODE    4
`define ST2_INPUT_THREE         3
`define ST2_INPUT_TWO           2
`define ST2_INPUT_ONE           1
`define ST2_SUPPLY              0

// ----------------------------------------------------------------------
// conversion timing, in mclk cycles
// ----------------------------------------------------------------------
`define CONVERSION_CYCLES       16'h0100
`define IDLE_GAP_CYCLES         16'h0400

`endif

// ### logic/sticky_flags.v
/*
  A group of sticky flags: hardware sets, a read of the whole byte clears.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
  parameter WIDTH = 4
) (
  input  wire             mclk,
  input  wire             reset,
  input  wire [WIDTH-1:0] set,
  input  wire             clear,
  output reg  [WIDTH-1:0] flags
);

  // a trip landing in the clearing cycle survives the clear
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      flags <= {WIDTH{1'b0}};
    end else if (clear) begin
      flags <= set;
    end else begin
      flags <= flags | set;
    end
  end

endmodule

`default_nettype wire

// ### logic/conversion_sequencer.v
/*
  Autonomous conversion sequencer: walks the seven measurement channels,
  skipping disabled ones, then rests for an idle gap and starts again.
  Channel order: 0 internal, 1 remote one, 2 remote two, 3 supply,
  4 input one, 5 input two, 6 input three.
  Assumes run and skip come from registers on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "monitor_regs_map.vh"

module conversion_sequencer #(
  parameter CHANNELS   = 7,
  parameter CONV_COUNT = `CONVERSION_CYCLES,
  parameter IDLE_COUNT = `IDLE_GAP_CYCLES
) (
  input  wire                mclk,
  input  wire                reset,
  input  wire                run,
  input  wire [CHANNELS-1:0] skip,
  output reg                 busy,
  output reg  [2:0]          channel,
  output reg                 channel_start
);

  localparam IDLE = 1'b0;
  localparam CONV = 1'b1;

  reg        state;
  reg [15:0] count;
  reg        found;
  reg [2:0]  next_channel;
  integer    i;

  // next enabled channel above the current one, or the first when idle
  always @* begin
    found        = 1'b0;
    next_channel = 3'h0;
    for (i = CHANNELS - 1; i >= 0; i = i - 1) begin
      if (!skip[i] && (state == IDLE || i > channel)) begin
        found        = 1'b1;
        next_channel = i[2:0];
      end
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state         <= IDLE;
      count         <= 16'h0000;
      busy          <= 1'b0;
      channel       <= 3'h0;
      channel_start <= 1'b0;
    end else begin
      channel_start <= 1'b0;
      if (!run) begin
        // standby stops a conversion in flight, no waiting for its end
        state <= IDLE;
        count <= 16'h0000;
        busy  <= 1'b0;
      end else begin
        case (state)
          IDLE: begin
            if (count != 16'h0000) begin
              count <= count - 16'h0001;
            end else if (found) begin
              state         <= CONV;
              channel       <= next_channel;
              channel_start <= 1'b1;
              busy          <= 1'b1;
              count         <= CONV_COUNT[15:0] - 16'h0001;
            end
          end
          CONV: begin
            if (count != 16'h0000) begin
              count <= count - 16'h0001;
            end else if (found) begin
              channel       <= next_channel;
              channel_start <= 1'b1;
              count         <= CONV_COUNT[15:0] - 16'h0001;
            end else begin
              state <= IDLE;
              busy  <= 1'b0;
              count <= IDLE_COUNT[15:0];
            end
          end
          default: begin
            state <= IDLE;
            busy  <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### tb/regs_checker.sv
/*
  Port assertions for the monitor configuration and status block.
  Assumes it is bound to monitor_config_status_regs on the single mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module regs_checker #(
  parameter CONV_COUNT = 4,
  parameter IDLE_COUNT = 8
) (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       internal_over_limit,
  input wire logic       remote_one_over_limit,
  input wire logic       remote_two_over_limit,
  input wire logic       supply_window_trip,
  input wire logic       alert_n,
  input wire logic       overtemp_output_n,
  input wire logic       standby,
  input wire logic       busy,
  input wire logic       conv_start
);
  // ----------------------------------------------------------------------
  // mask byte mirror: keeps mask checks free of hierarchical paths
  // ----------------------------------------------------------------------
  logic [7:0] cfg1;
  always @(posedge mclk or posedge reset)
    if (reset)
      cfg1 <= 8'h00;
    else if (reg_write && reg_addr == 8'h09)
      cfg1 <= reg_wdata;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  a_standby_stops_busy: assert property (standby |=> !busy)
    else $error("busy high in standby");
  a_start_sets_busy: assert property (conv_start |-> busy)
    else $error("conversion start without busy");
  a_standby_follows_write: assert property (reg_write && reg_addr == 8'h09 |=> standby == $past(reg_wdata[6]))
    else $error("standby differs from written bit");
  a_reserved_reads_zero: assert property (reg_read && reg_addr == 8'h33 |=> !reg_rdata[0])
    else $error("reserved bit reads one");
  a_idle_busy_bit: assert property (reg_read && reg_addr == 8'h02 && standby && !busy |=> !reg_rdata[7])
    else $error("busy bit set while idle");
  a_mask_all_quiet: assert property (cfg1[7] |=> alert_n)
    else $error("alert while all masked");
  a_internal_overtemp: assert property (internal_over_limit |=> !overtemp_output_n)
    else $error("internal overtemp not driven");
  a_overtemp_release: assert property (!(internal_over_limit || remote_one_over_limit || remote_two_over_limit) |=> overtemp_output_n)
    else $error("overtemp held without cause");
  a_remote_one_overtemp: assert property (remote_one_over_limit && !cfg1[5] |=> !overtemp_output_n)
    else $error("remote one overtemp not driven");
  a_supply_alert_falls: assert property (supply_window_trip && !cfg1[7] && !cfg1[0] |=> ##1 !alert_n)
    else $error("supply trip gave no alert");

  c_start: cover property (conv_start);
  c_alert: cover property (!alert_n);
  c_overtemp: cover property (!overtemp_output_n);
endmodule
bind monitor_config_status_regs regs_checker #(.CONV_COUNT(CONV_COUNT), .IDLE_COUNT(IDLE_COUNT)) i_regs_checker (.*);
`default_nettype wire

// ### tb/host_model.sv
/*
  Behavioural host: turns byte accesses into one-cycle register strobes.
  Assumes the serial front end is abstracted away; idle lines carry inverted junk.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       mclk,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_write,
  output var  logic       reg_read,
  output var  logic [7:0] reg_wdata
);
  initial {reg_addr, reg_write, reg_read, reg_wdata} = 18'h00000;
  // released lines flip so a stale address or data is never mistaken for valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule
`default_nettype wire

// ### tb/monitor_config_status_regs_tb.sv
/*
  Self-checking bench for the monitor configuration and status block.
  Assumes the host model drives strobes and the bench drives comparator inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module monitor_config_status_regs_tb;
  logic       mclk;
  logic       reset = 1'b1;
  logic [5:0] tt    = 6'h00;
  logic [3:0] vt    = 4'h0;
  logic [1:0] df    = 2'h0;
  logic [2:0] ol    = 3'h0;
  logic [7:0] r;
  logic [7:0] exp_q[$];
  int         err_total, comparisons, j, m;
  wire  [7:0] reg_addr, reg_wdata, reg_rdata;
  wire  [2:0] conv_channel;
  wire        reg_write, reg_read, alert_n, overtemp_output_n, standby, busy, conv_start;
  localparam logic [7:0] MSK [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h10, 8'h20, 8'h20, 8'h80, 8'h80};
  localparam int         SKB [7]  = '{5, 7, 6, 1, 2, 3, 4};

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  host_model i_host_model (.mclk(mclk), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata));
  monitor_config_status_regs #(.CONV_COUNT(4), .IDLE_COUNT(8)) i_monitor_config_status_regs (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .internal_high_trip(tt[5]), .internal_low_trip(tt[4]), .remote_one_high_trip(tt[3]),
    .remote_one_low_trip(tt[2]), .remote_two_high_trip(tt[1]), .remote_two_low_trip(tt[0]),
    .remote_one_diode_fault(df[0]), .remote_two_diode_fault(df[1]),
    .internal_over_limit(ol[2]), .remote_one_over_limit(ol[1]), .remote_two_over_limit(ol[0]),
    .input_three_window_trip(vt[3]), .input_two_window_trip(vt[2]),
    .input_one_window_trip(vt[1]), .supply_window_trip(vt[0]), .alert_n(alert_n),
    .overtemp_output_n(overtemp_output_n), .standby(standby), .busy(busy),
    .conv_channel(conv_channel), .conv_start(conv_start));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_model.wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host_model.rd(a);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(input int k);
    @(posedge mclk);
    {tt, vt} <= 10'h001 << k;
    @(posedge mclk);
    {tt, vt} <= 10'h000;
  endtask
  task automatic wait_start();
    int n;
    n = 0;
    do begin
      settle(1);
      n++;
    end while (conv_start !== 1'b1 && n < 200);
    check("conv_start", {7'h00, conv_start}, 8'h01);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // read data lands on the same edge that takes the strobe
  always @(posedge mclk) begin
    if (reg_read === 1'b1) begin
      #1;
      check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    #160000;
    err_total++;
    final_report();
  end

  initial begin
    void'($urandom(70));
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    wait_start();
    check("busy", {7'h00, busy}, 8'h01);
    rd(8'h03, 8'h00);
    rd(8'h33, 8'h00);
    wr(8'h09, 8'h40);
    settle(1);
    check("busy", {7'h00, busy}, 8'h00);
    rd(8'h02, 8'h00);
    $display("test reset_standby done");
    for (j = 0; j < 10; j++) begin
      for (m = 0; m < 2; m++) begin
        wr(8'h09, m ? (8'h40 | MSK[j]) : 8'h40);
        pulse(j);
        settle(2);
        check("alert_n", {7'h00, alert_n}, m[7:0]);
        rd(j < 4 ? 8'h32 : 8'h02, 8'h01 << (j < 4 ? j : (j < 6 ? j - 4 : j - 3)));
        rd(j < 4 ? 8'h32 : 8'h02, 8'h00);
        settle(2);
        check("alert_n", {7'h00, alert_n}, 8'h01);
      end
    end
    $display("test alerts done");
    for (j = 0; j < 3; j++) begin
      for (m = 0; m < 2; m++) begin
        wr(8'h09, m ? (8'h40 | (8'h10 << j)) : 8'h40);
        ol <= 3'h1 << j;
        settle(2);
        check("overtemp_output_n", {7'h00, overtemp_output_n}, {7'h00, m == 1 && j < 2});
        rd(8'h32, 8'h20 << j);
        ol <= 3'h0;
        settle(2);
        check("overtemp_output_n", {7'h00, overtemp_output_n}, 8'h01);
        rd(8'h32, 8'h00);
      end
    end
    df <= 2'h3;
    rd(8'h02, 8'h04);
    rd(8'h32, 8'h10);
    df <= 2'h0;
    $display("test overtemp_diode done");
    for (j = 0; j < 4; j++) begin
      r = $urandom;
      wr(8'h09, r);
      wr(8'h02, ~r);
      rd(8'h03, r);
      check("standby", {7'h00, standby}, {7'h00, r[6]});
      wr(8'h34, r);
      rd(8'h33, r & 8'hFE);
    end
    rd(8'h55, 8'h00);
    $display("test config done");
    for (j = 0; j < 7; j++) begin
      wr(8'h34, 8'hFE ^ (8'h01 << SKB[j]));
      wr(8'h09, 8'h00);
      wait_start();
      wait_start();
      check("conv_channel", {5'h00, conv_channel}, j[7:0]);
      wr(8'h09, 8'h40);
    end
    $display("test skip done");
    final_report();
  end
endmodule
`default_nettype wire
